//--- logic/supply_monitor_watchdog_ctl_regs.svh
// register addresses, field positions, reset values and timing counts
`ifndef SUPPLY_MONITOR_WATCHDOG_CTL_REGS_SVH
`define SUPPLY_MONITOR_WATCHDOG_CTL_REGS_SVH

`define PSM_ADDR      8'hdf
`define PSM_RESET     8'hde
`define DOG_ADDR      8'ha7
`define DOG_RESET     8'h00

`define PSM_DOK       7
`define PSM_AOK       6
`define PSM_FAIL      5
`define PSM_TPD_LSB   3
`define PSM_TPA_LSB   1
`define PSM_EN        0

`define DOG_UNLOCK    0
`define DOG_ARM       1
`define DOG_STAT      2
`define DOG_RESP      3
`define DOG_PRE_LSB   4

`define DTRIP_MV_00   13'd4630
`define DTRIP_MV_01   13'd3080
`define DTRIP_MV_10   13'd2930
`define DTRIP_MV_11   13'd2630

`define CLK_NS        40
`define LF_HZ         32768
`define RECOVER_MS    250
`define RECOVER_TICKS ((`RECOVER_MS * `LF_HZ + 999) / 1000)
`define GLITCH_NS     2000
`define GLITCH_CYCLES ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- logic/supply_monitor_watchdog_ctl_pkg.sv
// types shared by the supply monitor and watchdog control logic
package supply_monitor_watchdog_ctl_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic [3:0] pre;
        logic       resp;
        logic       stat;
        logic       arm;
        logic       unlock;
    } dog_ctl_t;

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_NEW,
        UNL_OPEN
    } unlock_t;

endpackage

//--- logic/supply_monitor_watchdog_ctl.sv
// watchdog control bits, write unlock and supply monitor with its register
//
// How it works
// - writing one to arm enables watchdog and pulses its counter clear
// - unkicked expiry gives reset or interrupt per response select
// - arm clears on write zero, dog reset, hardware reset, supply interrupt
// - dog register write accepted only right after unlock instruction
// - enabled monitor flags low on analog or digital comparator
// - each supply threshold chosen from four levels 2.63 V to 4.63 V
// - supply fail flag interrupts core only when its enable is set
// - fail flag holds until supplies good continuously for 250 ms, or software clears it while both are good
// - comparator glitches shorter than filter time never set the fail flag
// - monitor register at 0xdf, resets to 0xde, byte access only
// - interrupt response gives unmaskable high priority interrupt, no reset
// - software clear of fail flag ignored while any comparator low
// - monitor runs only while its enable bit holds one
`timescale 1ns/1ps
`include "supply_monitor_watchdog_ctl_regs.svh"

module supply_monitor_watchdog_ctl #(
    parameter int RECOVER_TICKS = `RECOVER_TICKS,
    parameter int GLITCH_CYCLES = `GLITCH_CYCLES
) (
    input  wire logic                                  mclk,
    input  wire logic                                  rst,
    input  wire logic                                  ce,
    input  supply_monitor_watchdog_ctl_pkg::sfr_req_t  sfr_req,
    input  wire logic                                  insn_done,
    input  wire logic                                  dog_timeout,
    input  wire logic                                  lf_tick,
    input  wire logic                                  irq_en_supply,
    input  wire logic                                  analog_supply_ok,
    input  wire logic                                  digital_supply_ok,
    output logic [7:0]                                 sfr_rdata,
    output logic                                       dog_armed,
    output logic                                       dog_count_clear,
    output logic                                       dog_reset_req,
    output logic                                       dog_irq,
    output logic [3:0]                                 dog_prescale,
    output logic                                       supply_monitor_on,
    output logic                                       supply_irq,
    output logic [1:0]                                 digital_trip_sel,
    output logic [1:0]                                 analog_trip_sel,
    output logic [12:0]                                digital_trip_mv
);
    import supply_monitor_watchdog_ctl_pkg::*;

    localparam int CW = $clog2(GLITCH_CYCLES + 1);
    localparam int RW = $clog2(RECOVER_TICKS + 1);
    localparam logic [7:0] PSM_RST = `PSM_RESET;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // per supply: two-flop sync, then a run-length glitch filter
    logic [1:0] ok_raw;
    logic [1:0] ok_sync;
    logic [1:0] low_filt;

    assign ok_raw = {digital_supply_ok, analog_supply_ok};

    for (genvar g = 0; g < 2; g++) begin : g_sup
        logic          s1_r;
        logic          s2_r;
        logic [CW-1:0] cnt_r;
        logic [CW-1:0] cnt_nxt;
        logic          low_r;
        logic          low_nxt;

        // a low shorter than the filter length never reaches the flag
        always_comb begin
            cnt_nxt = cnt_r;
            low_nxt = low_r;
            if (s2_r) begin
                cnt_nxt = '0;
                low_nxt = 1'b0;
            end else if (cnt_r == CW'(GLITCH_CYCLES - 1)) begin
                low_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                s1_r  <= 1'b1;
                s2_r  <= 1'b1;
                cnt_r <= '0;
                low_r <= 1'b0;
            end else if (ce) begin
                s1_r  <= ok_raw[g];
                s2_r  <= s1_r;
                cnt_r <= cnt_nxt;
                low_r <= low_nxt;
            end
        end

        assign ok_sync[g]  = s2_r;
        assign low_filt[g] = low_r;
    end

    logic dog_wr;
    logic psm_wr;
    logic psm_rd;
    logic dog_rd;

    assign dog_wr = sfr_req.wr && (sfr_req.addr == `DOG_ADDR);
    assign psm_wr = sfr_req.wr && (sfr_req.addr == `PSM_ADDR);
    assign psm_rd = sfr_req.rd && (sfr_req.addr == `PSM_ADDR);
    assign dog_rd = sfr_req.rd && (sfr_req.addr == `DOG_ADDR);

    // supply monitor state
    logic          mon_on_r;
    logic          mon_on_nxt;
    logic [1:0]    dtrip_r;
    logic [1:0]    dtrip_nxt;
    logic [1:0]    atrip_r;
    logic [1:0]    atrip_nxt;
    logic          flag_r;
    logic          flag_nxt;
    logic [RW-1:0] rec_r;
    logic [RW-1:0] rec_nxt;
    logic          sirq_nxt;
    logic [12:0]   dmv_nxt;
    logic          fail_any;
    logic          rec_done;

    assign fail_any = mon_on_r && (|low_filt);
    assign rec_done = flag_r && (&ok_sync) && lf_tick
                   && (rec_r == RW'(RECOVER_TICKS - 1));

    always_comb begin
        mon_on_nxt = mon_on_r;
        dtrip_nxt  = dtrip_r;
        atrip_nxt  = atrip_r;
        flag_nxt   = flag_r;
        rec_nxt    = rec_r;
        if (psm_wr) begin
            mon_on_nxt = sfr_req.wdata[`PSM_EN];
            dtrip_nxt  = sfr_req.wdata[`PSM_TPD_LSB +: 2];
            atrip_nxt  = sfr_req.wdata[`PSM_TPA_LSB +: 2];
            if (sfr_req.wdata[`PSM_FAIL])
                flag_nxt = 1'b1;
            else if (&ok_sync)
                flag_nxt = 1'b0;
        end
        // any low restarts the interval; good level counts slow ticks
        if (!flag_r || !(&ok_sync))
            rec_nxt = '0;
        else if (lf_tick && !rec_done)
            rec_nxt = rec_r + 1'b1;
        if (rec_done) begin
            flag_nxt = 1'b0;
            rec_nxt  = '0;
        end
        // hardware set wins over any clear in the same cycle
        if (fail_any)
            flag_nxt = 1'b1;
        sirq_nxt = flag_nxt && irq_en_supply;
        unique case (dtrip_nxt)
            2'b00:   dmv_nxt = `DTRIP_MV_00;
            2'b01:   dmv_nxt = `DTRIP_MV_01;
            2'b10:   dmv_nxt = `DTRIP_MV_10;
            2'b11:   dmv_nxt = `DTRIP_MV_11;
        endcase
    end

    // watchdog control state
    unlock_t    unl_r;
    unlock_t    unl_nxt;
    dog_ctl_t   dog_r;
    dog_ctl_t   dog_nxt;
    logic       clr_nxt;
    logic       rreq_nxt;
    logic       dirq_nxt;
    logic       wr_ok;
    logic       unl_set;
    logic [7:0] rdata_nxt;

    assign wr_ok   = dog_wr && (unl_r == UNL_OPEN);
    assign unl_set = dog_wr && sfr_req.wdata[`DOG_UNLOCK];

    always_comb begin
        unl_nxt  = unl_r;
        dog_nxt  = dog_r;
        clr_nxt  = 1'b0;
        rreq_nxt = 1'b0;
        dirq_nxt = 1'b0;
        // unlock lives until the end of the instruction after the one
        // that set it; no write in between means the core saw nothing
        unique case (unl_r)
            UNL_IDLE: begin
                if (unl_set)
                    unl_nxt = insn_done ? UNL_OPEN : UNL_NEW;
            end
            UNL_NEW: begin
                if (insn_done)
                    unl_nxt = UNL_OPEN;
            end
            UNL_OPEN: begin
                if (wr_ok || insn_done)
                    unl_nxt = UNL_IDLE;
            end
            default: unl_nxt = UNL_IDLE;
        endcase
        if (wr_ok) begin
            dog_nxt.pre  = sfr_req.wdata[`DOG_PRE_LSB +: 4];
            dog_nxt.resp = sfr_req.wdata[`DOG_RESP];
            dog_nxt.arm  = sfr_req.wdata[`DOG_ARM];
            if (!sfr_req.wdata[`DOG_STAT])
                dog_nxt.stat = 1'b0;
            clr_nxt = sfr_req.wdata[`DOG_ARM];
        end
        if (dog_timeout && dog_r.arm) begin
            dog_nxt.stat = 1'b1;
            if (dog_r.resp) begin
                dirq_nxt = 1'b1;
            end else begin
                rreq_nxt    = 1'b1;
                dog_nxt.arm = 1'b0;
            end
        end
        if (sirq_nxt && !supply_irq)
            dog_nxt.arm = 1'b0;
        dog_nxt.unlock = (unl_nxt != UNL_IDLE);
        rdata_nxt = sfr_rdata;
        if (psm_rd)
            rdata_nxt = {ok_sync[1], ok_sync[0], flag_r, dtrip_r, atrip_r, mon_on_r};
        else if (dog_rd)
            rdata_nxt = dog_r;
        else if (sfr_req.rd)
            rdata_nxt = 8'h00;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mon_on_r          <= PSM_RST[`PSM_EN];
            dtrip_r           <= PSM_RST[`PSM_TPD_LSB +: 2];
            atrip_r           <= PSM_RST[`PSM_TPA_LSB +: 2];
            flag_r            <= PSM_RST[`PSM_FAIL];
            rec_r             <= '0;
            unl_r             <= UNL_IDLE;
            dog_r             <= `DOG_RESET;
            sfr_rdata         <= 8'h00;
            dog_count_clear   <= 1'b0;
            dog_reset_req     <= 1'b0;
            dog_irq           <= 1'b0;
            supply_irq        <= 1'b0;
            digital_trip_mv   <= `DTRIP_MV_11;
        end else if (ce) begin
            mon_on_r          <= mon_on_nxt;
            dtrip_r           <= dtrip_nxt;
            atrip_r           <= atrip_nxt;
            flag_r            <= flag_nxt;
            rec_r             <= rec_nxt;
            unl_r             <= unl_nxt;
            dog_r             <= dog_nxt;
            sfr_rdata         <= rdata_nxt;
            dog_count_clear   <= clr_nxt;
            dog_reset_req     <= rreq_nxt;
            dog_irq           <= dirq_nxt;
            supply_irq        <= sirq_nxt;
            digital_trip_mv   <= dmv_nxt;
        end
    end

    // these mirror flops directly so every output stays registered
    assign dog_armed         = dog_r.arm;
    assign dog_prescale      = dog_r.pre;
    assign supply_monitor_on = mon_on_r;
    assign digital_trip_sel  = dtrip_r;
    assign analog_trip_sel   = atrip_r;

    sequence s_unlock_new;
        ce && unl_r == UNL_NEW && insn_done;
    endsequence

    sequence s_open_lapse;
        ce && unl_r == UNL_OPEN && insn_done && !dog_wr;
    endsequence

    a_unlock_opens: assert property (s_unlock_new |=> unl_r == UNL_OPEN)
        else $error("unlock did not open after its instruction");

    a_unlock_lapses: assert property (s_open_lapse |=> unl_r == UNL_IDLE)
        else $error("unlock survived an instruction without a write");

    a_locked_write: assert property (
        ce && dog_wr && unl_r != UNL_OPEN && !dog_timeout && !(sirq_nxt && !supply_irq)
        |=> $stable(dog_r.arm))
        else $error("locked write changed the arm bit");

    a_arm_kick: assert property (
        ce && wr_ok && sfr_req.wdata[`DOG_ARM] && !dog_timeout && !(sirq_nxt && !supply_irq)
        |=> dog_armed && dog_count_clear)
        else $error("arm write did not arm and clear counters");

    a_dog_reset: assert property (
        ce && dog_timeout && dog_armed && !dog_r.resp
        |=> dog_reset_req && !dog_armed && !dog_irq)
        else $error("expiry with reset response misbehaved");

    a_dog_irq: assert property (
        ce && dog_timeout && dog_armed && dog_r.resp |=> dog_irq && !dog_reset_req)
        else $error("expiry with interrupt response misbehaved");

    a_fail_sets: assert property (ce && fail_any |=> flag_r)
        else $error("filtered low did not set the fail flag");

    a_clear_refused: assert property (
        ce && psm_wr && !sfr_req.wdata[`PSM_FAIL] && flag_r && !(&ok_sync) |=> flag_r)
        else $error("fail flag cleared while a supply was low");

    a_irq_gated: assert property (
        ce |=> supply_irq == ($past(flag_nxt) && $past(irq_en_supply)))
        else $error("supply interrupt not gated by its enable");

    a_glitch_blocked: assert property (
        ce && !flag_r && !psm_wr && !(|low_filt) && mon_on_r |=> !flag_r)
        else $error("fail flag set without a filtered low");

    a_recovery_hold: assert property (
        ce && flag_r && !rec_done && !psm_wr |=> flag_r)
        else $error("fail flag dropped before the recovery interval");

    a_supply_disarm: assert property (
        ce && sirq_nxt && !supply_irq |=> !dog_armed)
        else $error("supply interrupt left the watchdog armed");

endmodule

//--- test/supply_monitor_watchdog_ctl_bench.sv
// self-checking bench for the supply monitor and watchdog control block
`timescale 1ns/1ps

module supply_monitor_watchdog_ctl_bench;
    import supply_monitor_watchdog_ctl_pkg::*;

    localparam int GCYC = 3;
    localparam int RTICKS = 4;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    sfr_req_t    sfr_req = '0;
    logic        insn_done = 1'b0;
    logic        dog_timeout = 1'b0;
    logic        lf_tick = 1'b0;
    logic        irq_en_supply = 1'b0;
    logic        analog_supply_ok = 1'b1;
    logic        digital_supply_ok = 1'b1;
    logic [7:0]  sfr_rdata;
    logic        dog_armed;
    logic        dog_count_clear;
    logic        dog_reset_req;
    logic        dog_irq;
    logic [3:0]  dog_prescale;
    logic        supply_monitor_on;
    logic        supply_irq;
    logic [1:0]  digital_trip_sel;
    logic [1:0]  analog_trip_sel;
    logic [12:0] digital_trip_mv;
    logic [7:0]  v;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;

    supply_monitor_watchdog_ctl #(.RECOVER_TICKS(RTICKS), .GLITCH_CYCLES(GCYC)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .sfr_req(sfr_req), .insn_done(insn_done),
        .dog_timeout(dog_timeout), .lf_tick(lf_tick), .irq_en_supply(irq_en_supply),
        .analog_supply_ok(analog_supply_ok), .digital_supply_ok(digital_supply_ok),
        .sfr_rdata(sfr_rdata), .dog_armed(dog_armed), .dog_count_clear(dog_count_clear),
        .dog_reset_req(dog_reset_req), .dog_irq(dog_irq), .dog_prescale(dog_prescale),
        .supply_monitor_on(supply_monitor_on), .supply_irq(supply_irq),
        .digital_trip_sel(digital_trip_sel), .analog_trip_sel(analog_trip_sel),
        .digital_trip_mv(digital_trip_mv));

    always #20 mclk = ~mclk;

    // generous ceiling; the full sequence needs about 140 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
        // idle edge first, so back-to-back calls never redrive in one step
        tick(1);
        sfr_req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
        insn_done = done;
        tick(1);
        sfr_req = '0;
        insn_done = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        tick(1);
        sfr_req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        tick(1);
        d = sfr_rdata;
        sfr_req = '0;
    endtask

    // unlock instruction ends with insn_done, so the next write lands in the open window
    task automatic arm(input logic [7:0] d);
        wr(8'ha7, 8'h01, 1'b1);
        wr(8'ha7, d, 1'b0);
    endtask

    task automatic lf(input int n);
        repeat (n) begin
            lf_tick = 1'b1;
            tick(1);
            lf_tick = 1'b0;
            tick(1);
        end
    endtask

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic test_reset();
        rd(8'hdf, v);
        check(v, 8'hde);
        rd(8'h55, v);
        check(v, 8'h00);
        check(digital_trip_mv, 13'd2630);
        check(dog_armed, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_unlock();
        wr(8'ha7, 8'h72, 1'b0);
        tick(1);
        check(dog_armed, 1'b0);
        arm(8'h72);
        check(dog_armed, 1'b1);
        check(dog_count_clear, 1'b1);
        check(dog_prescale, 4'h7);
        tick(1);
        check(dog_count_clear, 1'b0);
        // an unrelated instruction between unlock and write closes the window
        wr(8'ha7, 8'h01, 1'b1);
        wr(8'h00, 8'h00, 1'b1);
        wr(8'ha7, 8'h70, 1'b0);
        tick(1);
        check(dog_armed, 1'b1);
        $display("test unlock done");
    endtask

    task automatic test_expiry();
        dog_timeout = 1'b1;
        tick(1);
        dog_timeout = 1'b0;
        for (int i = 0; i < 4 && dog_reset_req !== 1'b1; i++) tick(1);
        check(dog_reset_req, 1'b1);
        tick(1);
        check(dog_armed, 1'b0);
        rd(8'ha7, v);
        check(v & 8'h04, 8'h04);
        arm(8'h7a);
        dog_timeout = 1'b1;
        tick(1);
        dog_timeout = 1'b0;
        for (int i = 0; i < 4 && dog_irq !== 1'b1; i++) tick(1);
        check(dog_irq, 1'b1);
        check(dog_reset_req, 1'b0);
        tick(1);
        check(dog_armed, 1'b1);
        arm(8'h78);
        check(dog_armed, 1'b0);
        $display("test expiry done");
    endtask

    task automatic test_trip();
        logic [12:0] mv [4];
        logic [1:0]  c;
        mv = '{13'd4630, 13'd3080, 13'd2930, 13'd2630};
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(8'hdf, {3'b000, c, c, 1'b0}, 1'b0);
            tick(1);
            check(digital_trip_sel, c);
            check(analog_trip_sel, c);
            check(digital_trip_mv, mv[i]);
        end
        $display("test trip done");
    endtask

    task automatic test_supply();
        irq_en_supply = 1'b1;
        arm(8'h72);
        wr(8'hdf, 8'h01, 1'b0);
        analog_supply_ok = 1'b0;
        tick(GCYC - 1);
        analog_supply_ok = 1'b1;
        tick(10);
        check(supply_irq, 1'b0);
        digital_supply_ok = 1'b0;
        for (int i = 0; i < 20 && supply_irq !== 1'b1; i++) tick(1);
        check(supply_irq, 1'b1);
        tick(2);
        check(dog_armed, 1'b0);
        wr(8'hdf, 8'h01, 1'b0);
        rd(8'hdf, v);
        check(v & 8'ha0, 8'h20);
        digital_supply_ok = 1'b1;
        tick(4);
        lf(RTICKS - 1);
        // a one-cycle dip must restart the recovery count
        analog_supply_ok = 1'b0;
        tick(1);
        analog_supply_ok = 1'b1;
        tick(4);
        lf(RTICKS - 1);
        rd(8'hdf, v);
        check(v & 8'h20, 8'h20);
        lf(1);
        tick(3);
        rd(8'hdf, v);
        check(v & 8'h20, 8'h00);
        check(supply_irq, 1'b0);
        irq_en_supply = 1'b0;
        wr(8'hdf, 8'h21, 1'b0);
        tick(1);
        check(supply_irq, 1'b0);
        irq_en_supply = 1'b1;
        tick(2);
        check(supply_irq, 1'b1);
        wr(8'hdf, 8'h01, 1'b0);
        tick(1);
        check(supply_irq, 1'b0);
        $display("test supply done");
    endtask

    task automatic test_off();
        wr(8'hdf, 8'h00, 1'b0);
        analog_supply_ok = 1'b0;
        tick(12);
        check(supply_monitor_on, 1'b0);
        rd(8'hdf, v);
        check(v, 8'h80);
        analog_supply_ok = 1'b1;
        tick(3);
        // a frozen enable must swallow a register write
        ce = 1'b0;
        wr(8'hdf, 8'h01, 1'b0);
        ce = 1'b1;
        tick(1);
        check(supply_monitor_on, 1'b0);
        $display("test off done");
    endtask

    initial begin
        tick(5);
        rst = 1'b0;
        test_reset();
        test_unlock();
        test_expiry();
        test_trip();
        test_supply();
        test_off();
        stop_test();
    end

endmodule
